/* rtl/pfb_pkg.sv */
// Purpose: shared constants and types for pin function and boot select
// Assumes: single 50 MHz core clock
// Notes: boot codes are one-hot
package pfb_pkg;

  localparam int PFB_PORT_A_W = 8;
  localparam int PFB_PORT_B_W = 8;
  localparam int PFB_PORT_C_W = 8;
  localparam int PFB_PORT_D_W = 8;
  localparam int PFB_PORT_E_W = 10;

  localparam logic [31:0] PFB_BANK_ZERO_BASE = 32'h0000_0000;
  localparam logic [31:0] PFB_BANK_ZERO_LAST = 32'h07FF_FFFF;

  // port C bit positions of the upper address and bus direction, and the port D wait bit
  localparam int PFB_C_ADDR_LO = 2;
  localparam int PFB_C_ADDR_HI = 6;
  localparam int PFB_C_DIR_BIT = 7;
  localparam int PFB_D_WAIT_BIT = 0;

  // pin role after reset: all general-purpose
  localparam logic [9:0] PFB_SEL_RESET = 10'h000;

  typedef enum logic [2:0] {
    PFB_BOOT_FLASH = 3'h1,
    PFB_BOOT_EXTROM = 3'h2,
    PFB_BOOT_ROM = 3'h4
  } pfb_boot_t;

endpackage

/* rtl/pfb_pin_mux.sv */
// Purpose: shared pin role selection, secondary routing and boot device choice
// Assumes: pad inputs synchronous to core_clk; role selects held by software
// Notes: every pad and peripheral view is one flop behind its source
`timescale 1ns/1ns

module pfb_port_mux #(
  parameter int W = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [W-1:0] sel_req,
  input wire logic [W-1:0] force_sec,
  input wire logic [W-1:0] gpio_out,
  input wire logic [W-1:0] gpio_oe,
  input wire logic [W-1:0] irq_en,
  input wire logic [W-1:0] periph_out,
  input wire logic [W-1:0] periph_oe,
  input wire logic [W-1:0] pad_in,
  output logic [W-1:0] pad_out_q,
  output logic [W-1:0] pad_oe_q,
  output logic [W-1:0] gpio_in_q,
  output logic [W-1:0] periph_in_q,
  output logic [W-1:0] irq_q
);
  logic [W-1:0] sec_d;
  logic [W-1:0] pad_in_prev_q;
  logic [W-1:0] out_d;
  logic [W-1:0] oe_d;

  assign sec_d = sel_req | force_sec;
  assign out_d = (sec_d & periph_out) | (~sec_d & gpio_out);
  assign oe_d = (sec_d & periph_oe) | (~sec_d & gpio_oe);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pad_out_q <= '0;
      pad_oe_q <= '0;
      gpio_in_q <= '0;
      periph_in_q <= '0;
      irq_q <= '0;
      // ones so a pin idling high does not look like an edge after reset
      pad_in_prev_q <= '1;
    end else begin
      pad_out_q <= out_d;
      pad_oe_q <= oe_d;
      gpio_in_q <= pad_in & ~sec_d;
      periph_in_q <= pad_in & sec_d;
      // rising edge only; level interrupts left to the port block
      irq_q <= pad_in & ~pad_in_prev_q & ~sec_d & irq_en;
      pad_in_prev_q <= pad_in;
    end
  end
endmodule

module pfb_pin_mux
  import pfb_pkg::*;
#(
  parameter bit HAS_FLASH = 1'b1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [1:0] boot_select,
  input wire logic dram_enable_n,
  input wire logic bus_active,
  input wire logic bus_write,
  input wire logic bus_sdram,
  input wire logic bus_io01,
  input wire logic [31:0] bus_addr,
  input wire logic [1:0] pwm_out,
  input wire logic [1:0] dma_request_clear_out,
  input wire logic [1:0] dma_terminal_count_out,
  input wire logic [7:1] dram_strobe_out,
  input wire logic [7:0] periph_a_out,
  input wire logic [7:0] periph_a_oe,
  input wire logic [7:6] periph_b_out,
  input wire logic [7:6] periph_b_oe,
  input wire logic [9:0] periph_e_out,
  input wire logic [9:0] periph_e_oe,
  input wire logic [7:0] sel_a,
  input wire logic [7:0] sel_b,
  input wire logic [7:0] sel_c,
  input wire logic [7:0] sel_d,
  input wire logic [9:0] sel_e,
  input wire logic [7:0] gpio_a_out,
  input wire logic [7:0] gpio_b_out,
  input wire logic [7:0] gpio_c_out,
  input wire logic [7:0] gpio_d_out,
  input wire logic [9:0] gpio_e_out,
  input wire logic [7:0] gpio_a_oe,
  input wire logic [7:0] gpio_b_oe,
  input wire logic [7:0] gpio_c_oe,
  input wire logic [7:0] gpio_d_oe,
  input wire logic [9:0] gpio_e_oe,
  input wire logic [7:0] irq_en_a,
  input wire logic [7:0] irq_en_b,
  input wire logic [7:0] irq_en_c,
  input wire logic [7:0] irq_en_d,
  input wire logic [9:0] irq_en_e,
  input wire logic [7:0] pad_a_in,
  input wire logic [7:0] pad_b_in,
  input wire logic [7:0] pad_c_in,
  input wire logic [7:0] pad_d_in,
  input wire logic [9:0] pad_e_in,
  output logic [7:0] pad_a_out_q,
  output logic [7:0] pad_b_out_q,
  output logic [7:0] pad_c_out_q,
  output logic [7:0] pad_d_out_q,
  output logic [9:0] pad_e_out_q,
  output logic [7:0] pad_a_oe_q,
  output logic [7:0] pad_b_oe_q,
  output logic [7:0] pad_c_oe_q,
  output logic [7:0] pad_d_oe_q,
  output logic [9:0] pad_e_oe_q,
  output logic [7:0] gpio_a_in_q,
  output logic [7:0] gpio_b_in_q,
  output logic [7:0] gpio_c_in_q,
  output logic [7:0] gpio_d_in_q,
  output logic [9:0] gpio_e_in_q,
  output logic [7:0] irq_a_q,
  output logic [7:0] irq_b_q,
  output logic [7:0] irq_c_q,
  output logic [7:0] irq_d_q,
  output logic [9:0] irq_e_q,
  output logic [7:0] periph_a_in_q,
  output logic [9:0] periph_e_in_q,
  output logic [1:0] dma_request_in_q,
  output logic sio_rx_q,
  output logic ext_wait_in_q,
  output logic ext_output_enable_n_q,
  output pfb_boot_t boot_dev_q,
  output logic boot_ready_q,
  output logic bank_zero_hit_q
);
  logic [7:0] b_pout;
  logic [7:0] b_poe;
  logic [7:0] c_pout;
  logic [7:0] d_pout;
  logic [7:0] d_force;
  logic [1:0] dma_req_d;
  logic sio_rx_d;
  logic wait_d;
  logic dir_d;
  logic oe_n_d;
  logic bank_zero_d;
  pfb_boot_t boot_d;

  assign b_pout = {periph_b_out, dma_terminal_count_out, dma_request_clear_out[1], 1'b0,
    dma_request_clear_out[0], 1'b0};
  assign b_poe = {periph_b_oe, 6'h3a};
  // direction forced low outside bank 0/1 cycles so slow devices see a read
  assign dir_d = bus_active & bus_io01 & bus_write;
  assign c_pout = {dir_d, bus_addr[23:19], pwm_out};
  assign d_pout = {dram_strobe_out, 1'b0};
  assign d_force = {8{~dram_enable_n}};
  // taken straight from the pads so these views keep one cycle of latency
  assign dma_req_d = {pad_b_in[2] & sel_b[2], pad_b_in[0] & sel_b[0]};
  assign sio_rx_d = pad_b_in[7] & sel_b[7];
  // wait is only honoured for bank 0/1 cycles
  assign wait_d = pad_d_in[PFB_D_WAIT_BIT] & (sel_d[PFB_D_WAIT_BIT] | ~dram_enable_n)
    & bus_active & bus_io01;
  assign oe_n_d = ~(bus_active & ~bus_write & ~bus_sdram);
  assign bank_zero_d = bus_active && (bus_addr <= PFB_BANK_ZERO_LAST);
  assign boot_d = boot_select[1] ? PFB_BOOT_ROM :
    (boot_select[0] || !HAS_FLASH) ? PFB_BOOT_EXTROM : PFB_BOOT_FLASH;

  pfb_port_mux #(.W(PFB_PORT_A_W)) u_port_a (
    .core_clk(core_clk), .rst(rst), .sel_req(sel_a), .force_sec(8'h00),
    .gpio_out(gpio_a_out), .gpio_oe(gpio_a_oe), .irq_en(irq_en_a),
    .periph_out(periph_a_out), .periph_oe(periph_a_oe), .pad_in(pad_a_in),
    .pad_out_q(pad_a_out_q), .pad_oe_q(pad_a_oe_q), .gpio_in_q(gpio_a_in_q),
    .periph_in_q(periph_a_in_q), .irq_q(irq_a_q));

  pfb_port_mux #(.W(PFB_PORT_B_W)) u_port_b (
    .core_clk(core_clk), .rst(rst), .sel_req(sel_b), .force_sec(8'h00),
    .gpio_out(gpio_b_out), .gpio_oe(gpio_b_oe), .irq_en(irq_en_b),
    .periph_out(b_pout), .periph_oe(b_poe), .pad_in(pad_b_in),
    .pad_out_q(pad_b_out_q), .pad_oe_q(pad_b_oe_q), .gpio_in_q(gpio_b_in_q),
    .periph_in_q(), .irq_q(irq_b_q));

  pfb_port_mux #(.W(PFB_PORT_C_W)) u_port_c (
    .core_clk(core_clk), .rst(rst), .sel_req(sel_c), .force_sec(8'h00),
    .gpio_out(gpio_c_out), .gpio_oe(gpio_c_oe), .irq_en(irq_en_c),
    .periph_out(c_pout), .periph_oe(8'hff), .pad_in(pad_c_in),
    .pad_out_q(pad_c_out_q), .pad_oe_q(pad_c_oe_q), .gpio_in_q(gpio_c_in_q),
    .periph_in_q(), .irq_q(irq_c_q));

  pfb_port_mux #(.W(PFB_PORT_D_W)) u_port_d (
    .core_clk(core_clk), .rst(rst), .sel_req(sel_d), .force_sec(d_force),
    .gpio_out(gpio_d_out), .gpio_oe(gpio_d_oe), .irq_en(irq_en_d),
    .periph_out(d_pout), .periph_oe(8'hfe), .pad_in(pad_d_in),
    .pad_out_q(pad_d_out_q), .pad_oe_q(pad_d_oe_q), .gpio_in_q(gpio_d_in_q),
    .periph_in_q(), .irq_q(irq_d_q));

  pfb_port_mux #(.W(PFB_PORT_E_W)) u_port_e (
    .core_clk(core_clk), .rst(rst), .sel_req(sel_e), .force_sec(PFB_SEL_RESET),
    .gpio_out(gpio_e_out), .gpio_oe(gpio_e_oe), .irq_en(irq_en_e),
    .periph_out(periph_e_out), .periph_oe(periph_e_oe), .pad_in(pad_e_in),
    .pad_out_q(pad_e_out_q), .pad_oe_q(pad_e_oe_q), .gpio_in_q(gpio_e_in_q),
    .periph_in_q(periph_e_in_q), .irq_q(irq_e_q));

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dma_request_in_q <= 2'h0;
      sio_rx_q <= 1'b0;
      ext_wait_in_q <= 1'b0;
      ext_output_enable_n_q <= 1'b1;
      bank_zero_hit_q <= 1'b0;
    end else begin
      dma_request_in_q <= dma_req_d;
      sio_rx_q <= sio_rx_d;
      ext_wait_in_q <= wait_d;
      ext_output_enable_n_q <= oe_n_d;
      bank_zero_hit_q <= bank_zero_d;
    end
  end

  // strap caught on the first edge after reset release, then frozen
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      boot_dev_q <= PFB_BOOT_FLASH;
      boot_ready_q <= 1'b0;
    end else if (!boot_ready_q) begin
      boot_dev_q <= boot_d;
      boot_ready_q <= 1'b1;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_e0_rise;
    (!sel_e[0] && irq_en_e[0] && !pad_e_in[0]) ##1 (!sel_e[0] && irq_en_e[0] && pad_e_in[0]);
  endsequence

  AST_BOOT_ROM: assert property (
    $rose(boot_ready_q) && $past(boot_select[1]) |-> boot_dev_q == PFB_BOOT_ROM)
    else $error("boot rom not chosen");
  AST_BOOT_EXT: assert property (
    $rose(boot_ready_q) && $past(boot_select) == 2'b01 |-> boot_dev_q == PFB_BOOT_EXTROM)
    else $error("ext rom not chosen");
  AST_BOOT_HOLD: assert property (
    boot_ready_q |=> $stable(boot_dev_q) && boot_ready_q)
    else $error("boot device changed");
  AST_BANK_ZERO: assert property (
    bus_active && bus_addr[31:27] == 5'h00 |=> bank_zero_hit_q)
    else $error("bank zero miss");
  AST_ADDR_GPIO: assert property (
    !sel_c[2] |=> pad_c_out_q[2] == $past(gpio_c_out[2]))
    else $error("port c bit 2 not gpio");
  AST_DRAM_LOCK: assert property (
    !dram_enable_n |=> pad_d_oe_q[7:1] == 7'h7f && gpio_d_in_q == 8'h00)
    else $error("port d not locked");
  AST_SEC_ISO: assert property (
    sel_a[3] |=> gpio_a_in_q[3] == 1'b0)
    else $error("secondary pin leaks to port");
  AST_IRQ: assert property (s_e0_rise |=> irq_e_q[0]) else $error("edge irq lost");
  AST_DIR: assert property (
    sel_c[7] && bus_active && bus_io01 |=> pad_c_out_q[7] == $past(bus_write))
    else $error("bad bus direction");
  AST_DIR_IDLE: assert property (
    sel_c[7] && !(bus_active && bus_io01) |=> !pad_c_out_q[7])
    else $error("direction high off bank 0/1");
  AST_WAIT: assert property (
    (sel_d[0] || !dram_enable_n) && bus_active && bus_io01 && pad_d_in[0] |=> ext_wait_in_q)
    else $error("wait dropped");
  AST_DMA: assert property (
    sel_b[0] |=> dma_request_in_q[0] == $past(pad_b_in[0]))
    else $error("dma request not routed");
  AST_OE_SDRAM: assert property (
    bus_active && bus_sdram |=> ext_output_enable_n_q)
    else $error("oe strobe on sdram");
endmodule

/* tb/pfb_board_dev.sv */
// Purpose: board device that holds off I/O bank 0/1 accesses
// Assumes: wait line driven only while its bank is addressed
// Notes: no pull on the line, so it wanders when unselected
`timescale 1ns/1ns
module pfb_board_dev (
  input wire logic core_clk,
  input wire logic sel,
  input wire logic slow,
  output logic wait_pin
);
  logic last_q = 1'b0;
  always_ff @(posedge core_clk) begin
    last_q <= wait_pin;
  end
  // released line shows the inverse of its last level
  assign wait_pin = sel ? slow : ~last_q;
endmodule

/* tb/pfb_pin_mux_tb.sv */
// Purpose: self-checking bench for pfb_pin_mux
// Assumes: inputs driven by NBA at the rising edge
// Notes: outputs judged one cycle after inputs land
`timescale 1ns/1ns
module pfb_pin_mux_tb;
  import pfb_pkg::*;
  logic core_clk, rst, dram_enable_n, bus_active, bus_write, bus_sdram, bus_io01, slow;
  logic wait_pin, sio_rx_q, ext_wait_in_q, ext_output_enable_n_q, boot_ready_q;
  logic bank_zero_hit_q;
  logic [1:0] boot_select, pwm_out, dma_request_clear_out, dma_terminal_count_out;
  logic [1:0] dma_request_in_q;
  logic [31:0] bus_addr;
  logic [7:1] dram_strobe_out, pad_d_up;
  logic [7:6] periph_b_out, periph_b_oe;
  logic [7:0] periph_a_out, periph_a_oe, sel_a, sel_b, sel_c, sel_d, pad_a_in, pad_b_in;
  logic [7:0] pad_c_in, gpio_a_out, gpio_b_out, gpio_c_out, gpio_d_out, gpio_a_oe;
  logic [7:0] gpio_b_oe, gpio_c_oe, gpio_d_oe, irq_en_a, irq_en_b, irq_en_c, irq_en_d;
  logic [7:0] pad_a_out_q, pad_b_out_q, pad_c_out_q, pad_d_out_q, pad_a_oe_q, pad_b_oe_q;
  logic [7:0] pad_c_oe_q, pad_d_oe_q, gpio_a_in_q, gpio_b_in_q, gpio_c_in_q, gpio_d_in_q;
  logic [7:0] irq_a_q, irq_b_q, irq_c_q, irq_d_q, periph_a_in_q;
  logic [9:0] periph_e_out, periph_e_oe, sel_e, gpio_e_out, gpio_e_oe, irq_en_e, pad_e_in;
  logic [9:0] pad_e_out_q, pad_e_oe_q, gpio_e_in_q, irq_e_q, periph_e_in_q;
  wire logic [7:0] pad_d_in = {pad_d_up, wait_pin};
  pfb_boot_t boot_dev_q;
  int err_count = 0;
  int n_compared = 0;

  pfb_board_dev u_board (.core_clk(core_clk), .sel(bus_active & bus_io01), .slow(slow),
    .wait_pin(wait_pin));
  pfb_pin_mux u_dut (.*);

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // let the edge's updates land before looking
  task automatic tick;
    @(posedge core_clk);
    #1;
  endtask

  task automatic t_boot(input logic [1:0] bs, input logic [2:0] exp);
    @(posedge core_clk);
    rst <= 1'b1;
    boot_select <= bs;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    tick;
    tick;
    chk("boot_dev_q", exp, boot_dev_q);
    chk("boot_ready_q", 1, boot_ready_q);
    @(posedge core_clk);
    boot_select <= ~bs;
    tick;
    tick;
    chk("boot_dev_q held", exp, boot_dev_q);
  endtask

  task automatic t_portc;
    @(posedge core_clk);
    {gpio_c_out, gpio_c_oe, bus_addr} <= {16'hA5FF, 32'h00A8_0000};
    tick;
    chk("pad_c_out_q", 8'hA5, pad_c_out_q);
    chk("pad_c_oe_q", 8'hFF, pad_c_oe_q);
    @(posedge core_clk);
    {sel_c, pwm_out, bus_active, bus_io01, bus_write} <= {8'hFF, 5'b10111};
    tick;
    chk("pad_c_out_q sec", 8'hD6, pad_c_out_q);
    chk("bank_zero_hit_q", 1, bank_zero_hit_q);
    @(posedge core_clk);
    {bus_write, bus_addr} <= {1'b0, 32'h0800_0000};
    tick;
    chk("pad_c_out_q read", 8'h02, pad_c_out_q);
    chk("bank_zero_hit_q", 0, bank_zero_hit_q);
    chk("oe_n read", 0, ext_output_enable_n_q);
    @(posedge core_clk);
    {bus_write, bus_io01, bus_sdram} <= 3'b100;
    tick;
    chk("dir other bank", 8'h02, pad_c_out_q);
    @(posedge core_clk);
    {bus_write, bus_io01, bus_sdram} <= 3'b001;
    tick;
    chk("oe_n sdram", 1, ext_output_enable_n_q);
  endtask

  task automatic t_roles(input logic s);
    @(posedge core_clk);
    {sel_a, sel_e} <= {18{s}};
    {gpio_a_out, periph_a_out, pad_a_in, gpio_a_oe, periph_a_oe} <= 40'h5A_C396_F00F;
    {gpio_e_out, periph_e_out, pad_e_in, gpio_e_oe, periph_e_oe} <=
      {10'h155, 10'h2AA, 10'h3C3, 10'h0F0, 10'h30F};
    tick;
    chk("pad_a_out_q", s ? 8'hC3 : 8'h5A, pad_a_out_q);
    chk("pad_a_oe_q", s ? 8'h0F : 8'hF0, pad_a_oe_q);
    chk("gpio_a_in_q", s ? 8'h00 : 8'h96, gpio_a_in_q);
    chk("periph_a_in_q", s ? 8'h96 : 8'h00, periph_a_in_q);
    chk("pad_e_out_q", s ? 10'h2AA : 10'h155, pad_e_out_q);
    chk("periph_e_in_q", s ? 10'h3C3 : 10'h000, periph_e_in_q);
    chk("pad_e_oe_q", s ? 10'h30F : 10'h0F0, pad_e_oe_q);
    chk("gpio_e_in_q", s ? 10'h000 : 10'h3C3, gpio_e_in_q);
  endtask

  task automatic t_dma;
    @(posedge core_clk);
    {sel_b, gpio_b_out, gpio_b_oe, periph_b_out, periph_b_oe} <= 28'hBF4_0405;
    {dma_request_clear_out, dma_terminal_count_out, pad_b_in} <= 12'h981;
    tick;
    chk("pad_b_out_q", 8'h58, pad_b_out_q & 8'h7A);
    chk("pad_b_oe_q", 8'h7A, pad_b_oe_q & 8'h7F);
    chk("dma_request_in_q", 2'b01, dma_request_in_q);
    chk("sio_rx_q", 1, sio_rx_q);
    chk("gpio_b_in_q", 8'h00, gpio_b_in_q);
  endtask

  task automatic t_dram;
    @(posedge core_clk);
    {dram_enable_n, sel_d, gpio_d_out, gpio_d_oe} <= {1'b0, 24'h00FF_FF};
    {dram_strobe_out, pad_d_up, bus_io01, bus_active, slow} <= {14'h2AFF, 3'b111};
    tick;
    chk("pad_d_out_q", 8'hAA, pad_d_out_q & 8'hFE);
    chk("gpio_d_in_q", 8'h00, gpio_d_in_q);
    chk("pad_d_oe_q", 8'hFE, pad_d_oe_q);
    chk("ext_wait_in_q", 1, ext_wait_in_q);
    @(posedge core_clk);
    bus_io01 <= 1'b0;
    repeat (3) begin
      tick;
      chk("wait other bank", 0, ext_wait_in_q);
    end
  endtask

  task automatic t_irq;
    @(posedge core_clk);
    {irq_en_a, irq_en_b, irq_en_c, irq_en_d, irq_en_e} <= '1;
    {sel_e, pad_c_in, pad_e_in} <= {10'h002, 18'h0_0000};
    {pad_a_in, pad_b_in} <= 16'h0000;
    @(posedge core_clk);
    {pad_a_in, pad_b_in, pad_c_in, pad_e_in} <= '1;
    tick;
    chk("irq_e_q", 10'h3FD, irq_e_q);
    chk("irq_a_q", 8'hFF, irq_a_q);
    chk("irq_b_q", 8'h40, irq_b_q);
    chk("irq_c_q", 8'h00, irq_c_q);
    chk("irq_d_q", 8'h00, irq_d_q);
    chk("gpio_c_in_q", 8'h00, gpio_c_in_q);
    tick;
    chk("irq_e_q pulse", 10'h000, irq_e_q);
  endtask

  initial begin
    {rst, bus_active, bus_write, bus_sdram, bus_io01, slow, boot_select, pwm_out} = '0;
    {dma_request_clear_out, dma_terminal_count_out, bus_addr, dram_strobe_out} = '0;
    {pad_d_up, periph_b_out, periph_b_oe, periph_a_out, periph_a_oe, sel_a, sel_b} = '0;
    {sel_c, sel_d, sel_e, pad_a_in, pad_b_in, pad_c_in, pad_e_in, gpio_a_out} = '0;
    {gpio_b_out, gpio_c_out, gpio_d_out, gpio_e_out, gpio_a_oe, gpio_b_oe} = '0;
    {gpio_c_oe, gpio_d_oe, gpio_e_oe, irq_en_a, irq_en_b, irq_en_c, irq_en_d} = '0;
    {irq_en_e, periph_e_out, periph_e_oe} = '0;
    rst = 1'b1;
    dram_enable_n = 1'b1;
    t_boot(2'b00, 3'h1);
    t_boot(2'b01, 3'h2);
    t_boot(2'b10, 3'h4);
    t_boot(2'b11, 3'h4);
    t_portc;
    t_roles(1'b1);
    t_roles(1'b0);
    t_dma;
    t_dram;
    t_irq;
    report_and_stop;
  end

  initial begin
    repeat (3000) @(posedge core_clk);
    err_count++;
    report_and_stop;
  end
endmodule
